// *** asqwm_defs.svh ***
// Register offsets, field positions and codes for the converter sequencer and window monitor.
`ifndef ASQWM_DEFS_SVH
`define ASQWM_DEFS_SVH
`define ASQWM_OFF_CONTROL_C     8'h00
`define ASQWM_OFF_AVERAGING_CONTROL   8'h04
`define ASQWM_OFF_INPUTCTRL 8'h08
`define ASQWM_OFF_SEQEN     8'h0C
`define ASQWM_OFF_SEQUENCE_STATUS 8'h10
`define ASQWM_OFF_RESULT    8'h14
`define ASQWM_OFF_WINLOW    8'h18
`define ASQWM_OFF_WINHIGH   8'h1C
`define ASQWM_OFF_INTERRUPT_FLAGS   8'h20
`define ASQWM_OFF_INTMASK   8'h24
`define ASQWM_OFF_SWTRIG    8'h28
`define ASQWM_SAMP_4        4'h2
`define ASQWM_SAMP_16       4'h4
`define ASQWM_SAMP_64       4'h6
`define ASQWM_SAMP_256      4'h8
`define ASQWM_INT_RESULT_READY_FLAG    0
`define ASQWM_INT_WINMATCH  1
`define ASQWM_RESP_OKAY     2'h0
`define ASQWM_RESP_SLVERR   2'h2
`endif

// *** asqwm_pkg.sv ***
// Types shared by the converter sequencer and window monitor.
package asqwm_pkg;
    typedef enum logic [2:0] {
        ASQWM_WIN_OFF     = 3'h0,
        ASQWM_WIN_ABOVE   = 3'h1,
        ASQWM_WIN_BELOW   = 3'h2,
        ASQWM_WIN_INSIDE  = 3'h3,
        ASQWM_WIN_OUTSIDE = 3'h4
    } asqwm_win_mode_t;
    typedef enum logic [1:0] {
        ASQWM_RES_12 = 2'h0,
        ASQWM_RES_16 = 2'h1,
        ASQWM_RES_10 = 2'h2,
        ASQWM_RES_8  = 2'h3
    } asqwm_res_t;
    typedef enum logic [1:0] {
        ASQWM_IDLE = 2'b00,
        ASQWM_CONV = 2'b01,
        ASQWM_NEXT = 2'b10
    } asqwm_state_t;
    typedef struct packed {
        logic        start;
        logic [4:0]  pos_sel;
        logic [4:0]  neg_sel;
        logic        diff;
    } asqwm_conv_req_t;
    typedef struct packed {
        logic        done;
        logic [15:0] value;
    } asqwm_conv_res_t;
endpackage

// *** asqwm_core.sv ***
// Converter sequencer, window monitor and AXI4-Lite register slave.
`timescale 1ns/1ps
`include "asqwm_defs.svh"
module asqwm_core
    import asqwm_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Trigger pin and analog core.
    input  wire logic        start_trig,
    output asqwm_conv_req_t  conv_req,
    input  wire asqwm_conv_res_t conv_res,
    // Interrupt.
    output logic             irq
);
    // Trigger pin is asynchronous, so it is synchronised before edge detection.
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= start_trig;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    // Register state.
    asqwm_win_mode_t win_mode_q, win_mode_d;
    asqwm_res_t      res_sel_q, res_sel_d;
    logic [3:0]  samp_q, samp_d;
    logic [2:0]  shift_q, shift_d;
    logic        diff_q, diff_d;
    logic [4:0]  pos_q, pos_d, neg_q, neg_d;
    logic [31:0] seq_en_q, seq_en_d;
    logic [15:0] win_lo_q, win_lo_d, win_hi_q, win_hi_d;
    logic [1:0]  flag_q, flag_d, mask_q, mask_d;
    logic [15:0] result_q, result_d;
    logic        busy_q, busy_d;
    logic [4:0]  cur_q, cur_d;
    logic [4:0]  last_q, last_d;
    logic [4:0]  seq_neg_q, seq_neg_d;
    logic        seq_diff_q, seq_diff_d;
    logic [31:0] pend_q, pend_d;
    logic        winchk_q, winchk_d;
    asqwm_state_t st_q, st_d;
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic        sw_start;

    // Lowest pending input index; each stage defers to the stages above it when its bit is clear.
    logic [4:0] low_idx [0:32];
    assign low_idx[32] = 5'h00;
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_prio
            assign low_idx[gi] = pend_q[gi] ? 5'(gi) : low_idx[gi+1];
        end
    endgenerate

    // Mask and sign-extend at the chosen resolution.
    function automatic logic signed [16:0] asqwm_fit(input logic [15:0] v, input asqwm_res_t r,
                                                    input logic sgn);
        logic signed [16:0] o;
        o = '0;
        unique case (r)
            ASQWM_RES_8:  o = {sgn ? {9{v[7]}} : 9'h000, v[7:0]};
            ASQWM_RES_10: o = {sgn ? {7{v[9]}} : 7'h00, v[9:0]};
            ASQWM_RES_12: o = {sgn ? {5{v[11]}} : 5'h00, v[11:0]};
            ASQWM_RES_16: o = {sgn ? v[15] : 1'b0, v};
        endcase
        return o;
    endfunction

    logic signed [16:0] cmp_r, cmp_lo, cmp_hi;
    logic               win_hit;
    // Signed only for a differential conversion; both sides use the same extension.
    always_comb begin
        cmp_r  = asqwm_fit(result_q, res_sel_q, seq_diff_q);
        cmp_lo = asqwm_fit(win_lo_q, res_sel_q, seq_diff_q);
        cmp_hi = asqwm_fit(win_hi_q, res_sel_q, seq_diff_q);
        unique case (win_mode_q)
            ASQWM_WIN_ABOVE:   win_hit = cmp_r > cmp_lo;
            ASQWM_WIN_BELOW:   win_hit = cmp_r < cmp_hi;
            ASQWM_WIN_INSIDE:  win_hit = (cmp_r > cmp_lo) && (cmp_r < cmp_hi);
            ASQWM_WIN_OUTSIDE: win_hit = (cmp_r < cmp_lo) || (cmp_r > cmp_hi);
            default:           win_hit = 1'b0;
        endcase
    end

    // AXI4-Lite channel handling; address and data are latched in either order.
    logic wr_go, rd_go;
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready  = !w_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign wr_go = aw_q && w_q && !bv_q;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign sw_start = wr_go && (awa_q == `ASQWM_OFF_SWTRIG) && wd_q[0];

    always_comb begin
        aw_d = aw_q; w_d = w_q; bv_d = bv_q; rv_d = rv_q;
        awa_d = awa_q; wd_d = wd_q; rd_d = rd_q;
        bresp_d = bresp_q; rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d  = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            bresp_d = (awa_q <= `ASQWM_OFF_SWTRIG && awa_q[1:0] == 2'h0 && awa_q != `ASQWM_OFF_SEQUENCE_STATUS
                       && awa_q != `ASQWM_OFF_RESULT) ? `ASQWM_RESP_OKAY : `ASQWM_RESP_SLVERR;
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (rv_q && s_axi_rready) rv_d = 1'b0;
        if (rd_go) begin
            rv_d = 1'b1;
            rresp_d = `ASQWM_RESP_OKAY;
            unique case (s_axi_araddr)
                `ASQWM_OFF_CONTROL_C:     rd_d = {27'h0, res_sel_q, win_mode_q};
                `ASQWM_OFF_AVERAGING_CONTROL:   rd_d = {25'h0, shift_q, samp_q};
                `ASQWM_OFF_INPUTCTRL: rd_d = {20'h0, diff_q, 1'b0, neg_q, pos_q};
                `ASQWM_OFF_SEQEN:     rd_d = seq_en_q;
                `ASQWM_OFF_SEQUENCE_STATUS: rd_d = {24'h0, busy_q, 2'h0, last_q};
                `ASQWM_OFF_RESULT:    rd_d = {16'h0, result_q};
                `ASQWM_OFF_WINLOW:    rd_d = {16'h0, win_lo_q};
                `ASQWM_OFF_WINHIGH:   rd_d = {16'h0, win_hi_q};
                `ASQWM_OFF_INTERRUPT_FLAGS:   rd_d = {30'h0, flag_q};
                `ASQWM_OFF_INTMASK:   rd_d = {30'h0, mask_q};
                `ASQWM_OFF_SWTRIG:    rd_d = 32'h0000_0000;
                default: begin
                    rd_d    = 32'h0000_0000;
                    rresp_d = `ASQWM_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
            awa_q <= 8'h00; wd_q <= 32'h0000_0000; rd_q <= 32'h0000_0000;
            bresp_q <= 2'h0; rresp_q <= 2'h0;
        end else begin
            aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
            awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
            bresp_q <= bresp_d; rresp_q <= rresp_d;
        end
    end
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata  = rd_q;
    assign s_axi_rresp  = rresp_q;

    // Configuration registers; any nonzero strobe writes the whole word, an all-zero strobe writes nothing.
    always_comb begin
        win_mode_d = win_mode_q; res_sel_d = res_sel_q; samp_d = samp_q; shift_d = shift_q;
        diff_d = diff_q; pos_d = pos_q; neg_d = neg_q; seq_en_d = seq_en_q;
        win_lo_d = win_lo_q; win_hi_d = win_hi_q; mask_d = mask_q;
        if (wr_go && s_axi_wstrb != 4'h0) begin
            unique case (awa_q)
                `ASQWM_OFF_CONTROL_C: begin
                    win_mode_d = asqwm_win_mode_t'(wd_q[2:0]);
                    res_sel_d  = asqwm_res_t'(wd_q[4:3]);
                end
                `ASQWM_OFF_AVERAGING_CONTROL: begin
                    samp_d  = wd_q[3:0];
                    shift_d = wd_q[6:4];
                end
                `ASQWM_OFF_INPUTCTRL: begin
                    pos_d  = wd_q[4:0];
                    neg_d  = wd_q[9:5];
                    diff_d = wd_q[11];
                end
                `ASQWM_OFF_SEQEN:   seq_en_d = wd_q;
                `ASQWM_OFF_WINLOW:  win_lo_d = wd_q[15:0];
                `ASQWM_OFF_WINHIGH: win_hi_d = wd_q[15:0];
                `ASQWM_OFF_INTMASK: mask_d   = wd_q[1:0];
                default: ;
            endcase
        end
    end

    // Sequencer; the negative input and mode are frozen for the whole sequence.
    always_comb begin
        st_d = st_q; busy_d = busy_q; cur_d = cur_q; last_d = last_q; pend_d = pend_q;
        seq_neg_d = seq_neg_q; seq_diff_d = seq_diff_q; result_d = result_q; winchk_d = 1'b0;
        flag_d = flag_q;
        unique case (st_q)
            ASQWM_IDLE: begin
                if (sw_start || (trig_s2_q && !trig_s3_q)) begin
                    busy_d     = 1'b1;
                    seq_neg_d  = neg_q;
                    seq_diff_d = diff_q;
                    pend_d     = (seq_en_q != 32'h0) ? seq_en_q : 32'h0;
                    cur_d      = pos_q;
                    st_d       = (seq_en_q != 32'h0) ? ASQWM_NEXT : ASQWM_CONV;
                end
            end
            ASQWM_NEXT: begin
                cur_d = low_idx[0];
                pend_d[low_idx[0]] = 1'b0;
                st_d  = ASQWM_CONV;
            end
            ASQWM_CONV: begin
                if (conv_res.done) begin
                    result_d = conv_res.value;
                    last_d   = cur_q;
                    winchk_d = 1'b1;
                    if (pend_q != 32'h0) begin
                        st_d = ASQWM_NEXT;
                    end else begin
                        st_d   = ASQWM_IDLE;
                        busy_d = 1'b0;
                    end
                end
            end
            default: st_d = ASQWM_IDLE;
        endcase
        // Write-one clears; a hardware set in the same cycle wins.
        if (wr_go && awa_q == `ASQWM_OFF_INTERRUPT_FLAGS) flag_d = flag_d & ~wd_q[1:0];
        if (st_q == ASQWM_CONV && conv_res.done) flag_d[`ASQWM_INT_RESULT_READY_FLAG] = 1'b1;
        if (winchk_q && win_hit) flag_d[`ASQWM_INT_WINMATCH] = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            win_mode_q <= ASQWM_WIN_OFF; res_sel_q <= ASQWM_RES_12;
            samp_q <= 4'h0; shift_q <= 3'h0; diff_q <= 1'b0;
            pos_q <= 5'h00; neg_q <= 5'h00; seq_en_q <= 32'h0000_0000;
            win_lo_q <= 16'h0000; win_hi_q <= 16'h0000; mask_q <= 2'h0;
            st_q <= ASQWM_IDLE; busy_q <= 1'b0; cur_q <= 5'h00; last_q <= 5'h00;
            pend_q <= 32'h0000_0000; seq_neg_q <= 5'h00; seq_diff_q <= 1'b0;
            result_q <= 16'h0000; winchk_q <= 1'b0; flag_q <= 2'h0;
        end else begin
            win_mode_q <= win_mode_d; res_sel_q <= res_sel_d;
            samp_q <= samp_d; shift_q <= shift_d; diff_q <= diff_d;
            pos_q <= pos_d; neg_q <= neg_d; seq_en_q <= seq_en_d;
            win_lo_q <= win_lo_d; win_hi_q <= win_hi_d; mask_q <= mask_d;
            st_q <= st_d; busy_q <= busy_d; cur_q <= cur_d; last_q <= last_d;
            pend_q <= pend_d; seq_neg_q <= seq_neg_d; seq_diff_q <= seq_diff_d;
            result_q <= result_d; winchk_q <= winchk_d; flag_q <= flag_d;
        end
    end

    // Request to the analog core; start is high for one cycle per conversion.
    logic start_q;
    always_ff @(posedge ref_clk) begin
        if (rst) start_q <= 1'b0;
        else     start_q <= (st_d == ASQWM_CONV) && (st_q != ASQWM_CONV);
    end
    assign conv_req.start   = start_q;
    assign conv_req.pos_sel = cur_q;
    assign conv_req.neg_sel = seq_neg_q;
    assign conv_req.diff    = seq_diff_q;
    assign irq = |(flag_q & mask_q);
endmodule

// *** asqwm_checker.sv ***
// Port assertions for the converter sequencer and window monitor.
`timescale 1ns/1ps
module asqwm_checker
    import asqwm_pkg::*;
(
    // Clock and reset.
    input wire logic            ref_clk,
    input wire logic            rst,
    // Bus handshakes.
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    // Analog core.
    input wire asqwm_conv_req_t conv_req,
    input wire asqwm_conv_res_t conv_res
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [2:0] gap_q;
    logic [2:0] gap_d;
    logic [4:0] pos_q;
    logic [4:0] pos_d;
    logic [5:0] neg_q;
    logic [5:0] neg_d;
    // A start soon after a done is a follow-on; manual starts come much later.
    always_comb begin
        gap_d = conv_res.done ? 3'h0 : gap_q + {2'h0, gap_q != 3'h7};
        pos_d = conv_req.start ? conv_req.pos_sel : pos_q;
        neg_d = conv_req.start ? {conv_req.neg_sel, conv_req.diff} : neg_q;
    end
    always_ff @(posedge ref_clk) begin
        gap_q <= rst ? 3'h7 : gap_d;
        pos_q <= pos_d;
        neg_q <= neg_d;
    end
    order_up_a: assert property (conv_req.start && gap_q < 3'h4 |-> conv_req.pos_sel > pos_q)
        else $error("sequence out of order");
    neg_fixed_a: assert property (conv_req.start && gap_q < 3'h4
        |-> {conv_req.neg_sel, conv_req.diff} == neg_q) else $error("negative input moved");
    start_pulse_a: assert property (conv_req.start |=> !conv_req.start)
        else $error("start is not a pulse");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read ready wrong");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
endmodule
bind asqwm_core asqwm_checker u_chk (
    .ref_clk(ref_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .conv_req(conv_req), .conv_res(conv_res)
);

// *** adc_sequencer_window_monitor_bench.sv ***
// Self-checking bench for the converter sequencer and window monitor.
`timescale 1ns/1ps
`include "asqwm_defs.svh"
module adc_sequencer_window_monitor_bench import asqwm_pkg::*;;
    logic            ref_clk, rst, start_trig, irq;
    logic            awvalid, awready, wvalid, wready, bvalid, bready;
    logic            arvalid, arready, rvalid, rready;
    logic [7:0]      awaddr, araddr;
    logic [31:0]     wdata, rdata, avg;
    logic [1:0]      bresp, rresp;
    asqwm_conv_req_t conv_req;
    asqwm_conv_res_t conv_res;
    logic [15:0]     resp_val;
    logic [5:0]      wait_q;
    logic [4:0]      cur_pos;
    logic [4:0]      pos_log [8];
    logic [4:0]      neg_log [8];
    int              conv_cnt, start_cnt, mismatches, check_count, k;
    // Window cases: control, thresholds, result, differential and expected match.
    logic [7:0]      w_ctl [8] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h1B, 8'h19};
    logic [15:0]     w_lo [8] = '{16'h100, 16'h100, 16'h0, 16'h10, 16'h10, 16'h0, 16'h80, 16'h1F0};
    logic [15:0]     w_hi [8] = '{16'h0, 16'h0, 16'h100, 16'h20, 16'h20, 16'h0, 16'h10, 16'h0};
    logic [15:0]     w_val [8] = '{16'h200, 16'h80, 16'h80, 16'h18, 16'h18, 16'h18, 16'h0, 16'hF8};
    logic [7:0]      w_diff = 8'h40;
    logic [7:0]      w_exp = 8'hCD;

    asqwm_core dut (
        .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .start_trig(start_trig),
        .conv_req(conv_req), .conv_res(conv_res), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Stand-in analog core; slow on purpose so status can be read mid-sequence.
    always @(posedge ref_clk) begin
        conv_res.done <= wait_q == 6'd1;
        conv_res.value <= wait_q == 6'd1 ? resp_val + {11'h0, cur_pos} : ~conv_res.value;
        if (wait_q == 6'd1) conv_cnt <= conv_cnt + 1;
        wait_q <= conv_req.start ? 6'd20 : wait_q - {5'h0, wait_q != 6'd0};
        if (conv_req.start) begin
            cur_pos <= conv_req.pos_sel;
            pos_log[start_cnt % 8] <= conv_req.pos_sel;
            neg_log[start_cnt % 8] <= conv_req.neg_sel;
            start_cnt <= start_cnt + 1;
        end
    end

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A wait that used up its bound counts as a mismatch and ends the run.
    task automatic limit(input int i);
        if (i >= 200) begin
            mismatches++;
            summarize();
        end
    endtask

    // Address and data go out together; each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
        int i;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        limit(i);
        chk(32'(bresp), 32'(err ? `ASQWM_RESP_SLVERR : `ASQWM_RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
        int i;
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        limit(i);
        chk(rdata, exp);
        chk(32'(rresp), 32'(err ? `ASQWM_RESP_SLVERR : `ASQWM_RESP_OKAY));
    endtask

    task automatic conv_wait(input int n);
        int i;
        for (i = 0; i < 200 && conv_cnt < n; i++) @(posedge ref_clk);
        limit(i);
        repeat (3) @(posedge ref_clk);
    endtask

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, start_trig} = 7'h40;
        {awaddr, araddr, wdata, conv_res, wait_q, cur_pos} = '0;
        {conv_cnt, start_cnt, mismatches, check_count} = '0;
        resp_val = 16'h0100;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values, an unmapped read and a refused write.
        rd(`ASQWM_OFF_SEQUENCE_STATUS, 32'h0);
        rd(`ASQWM_OFF_INTERRUPT_FLAGS, 32'h0);
        rd(8'h30, 32'h0, 1'b1);
        wr(`ASQWM_OFF_RESULT, 32'h1234, 1'b1);
        rd(`ASQWM_OFF_RESULT, 32'h0);
        // Each averaging code with its shift reads back.
        for (k = 0; k < 4; k++) begin
            avg = 32'((k == 1 ? 2 : k == 3 ? 0 : 1) * 16 + 2 * k + 2);
            wr(`ASQWM_OFF_AVERAGING_CONTROL, avg);
            rd(`ASQWM_OFF_AVERAGING_CONTROL, avg);
        end
        // No sequence bits: only the selected input converts; then mask and clear.
        wr(`ASQWM_OFF_INPUTCTRL, 32'h5);
        wr(`ASQWM_OFF_INTMASK, 32'h1);
        wr(`ASQWM_OFF_SWTRIG, 32'h1);
        conv_wait(1);
        chk(32'(pos_log[0]), 32'h5);
        chk(32'(start_cnt), 32'h1);
        rd(`ASQWM_OFF_RESULT, 32'h0105);
        rd(`ASQWM_OFF_SEQUENCE_STATUS, 32'h5);
        rd(`ASQWM_OFF_INTERRUPT_FLAGS, 32'h1);
        chk(32'(irq), 32'h1);
        wr(`ASQWM_OFF_INTMASK, 32'h0);
        chk(32'(irq), 32'h0);
        wr(`ASQWM_OFF_INTMASK, 32'h1);
        wr(`ASQWM_OFF_INTERRUPT_FLAGS, 32'h3);
        chk(32'(irq), 32'h0);
        // One pin edge runs inputs 0, 3 and 31 on a fixed negative input.
        wr(`ASQWM_OFF_SEQEN, 32'h8000_0009);
        wr(`ASQWM_OFF_INPUTCTRL, 32'h0000_08E0);
        start_trig <= 1'b1;
        repeat (4) @(posedge ref_clk);
        start_trig <= 1'b0;
        conv_wait(2);
        rd(`ASQWM_OFF_SEQUENCE_STATUS, 32'h80);
        conv_wait(4);
        for (k = 1; k < 4; k++) begin
            chk(32'(pos_log[k]), k == 1 ? 32'h0 : k == 2 ? 32'h3 : 32'h1F);
            chk(32'(neg_log[k]), 32'h7);
        end
        chk(32'(conv_req.diff), 32'h1);
        chk(32'(start_cnt), 32'h4);
        rd(`ASQWM_OFF_SEQUENCE_STATUS, 32'h1F);
        rd(`ASQWM_OFF_RESULT, 32'h011F);
        wr(`ASQWM_OFF_SEQEN, 32'h0);
        // Every mode, signed against unsigned, and 8-bit thresholds.
        for (k = 0; k < 8; k++) begin
            wr(`ASQWM_OFF_CONTROL_C, 32'(w_ctl[k]));
            wr(`ASQWM_OFF_INPUTCTRL, 32'(w_diff[k]) << 11);
            wr(`ASQWM_OFF_WINLOW, 32'(w_lo[k]));
            wr(`ASQWM_OFF_WINHIGH, 32'(w_hi[k]));
            wr(`ASQWM_OFF_INTERRUPT_FLAGS, 32'h3);
            resp_val <= w_val[k];
            wr(`ASQWM_OFF_SWTRIG, 32'h1);
            conv_wait(5 + k);
            rd(`ASQWM_OFF_INTERRUPT_FLAGS, {30'h0, w_exp[k], 1'b1});
        end
        summarize();
    end
endmodule
